/* pkg/oss_pkg.sv */
// constants, types and helpers of the output step sequencer
// Functional notes
// - idle drives regular output step values
// - steps execute in run; hold pauses them
// - start from idle begins at step one
// - start after hold resumes with remaining time
// - start after hold termination goes to jump step
// - hold control freezes output at present values
// - stop returns to idle and regular output
// - stop copies present output into regular step
// - branch moves to the step's branch target
// - step termination setting also changes state
// - loops built from jump step and count
// - separate jump counter kept for every step
// - jump count n runs block n+1 times; count zero repeats it forever
// - programmed step drives its sync code out
// - regular output step drives sync code false
// - end-phase waits for zero phase after time
// - output keeps step values during phase wait
// - jump step zero means next step
// - termination setting outranks jump step at end
// - step sync code is two bits
package oss_pkg;
    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int LVL_W = 16;
    localparam int TIME_W = 24;
    localparam int STEP_W = 8;
    localparam int JCNT_W = 10;
    localparam int SYNC_W = 2;
    localparam int ADDR_W = 6;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_UNIT_NS = 100000;
    localparam int TICK_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
    // ----------------------------------------
    // states, terminations, step codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        OSS_IDLE = 3'b001,
        OSS_RUN = 3'b010,
        OSS_HOLD = 3'b100
    } oss_state_e;
    localparam logic [1:0] TERM_CONT = 2'h0;
    localparam logic [1:0] TERM_HOLD = 2'h1;
    localparam logic [1:0] TERM_STOP = 2'h2;
    localparam logic [STEP_W-1:0] FIRST_STEP = 8'h01;
    localparam logic [STEP_W-1:0] STEP_NONE = 8'h00;
    localparam logic [JCNT_W-1:0] JCNT_INF = 10'h000;
    localparam logic [SYNC_W-1:0] SYNC_FALSE = 2'h0;
    // ----------------------------------------
    // register map and fields
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_REG_DC = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_REG_AC = 6'h0C;
    localparam logic [ADDR_W-1:0] ADDR_NUM_STEPS = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_STEP_SEL = 6'h14;
    localparam logic [ADDR_W-1:0] ADDR_STEP_LVL = 6'h18;
    localparam logic [ADDR_W-1:0] ADDR_STEP_TIME = 6'h1C;
    localparam logic [ADDR_W-1:0] ADDR_STEP_CFG = 6'h20;
    localparam logic [ADDR_W-1:0] ADDR_STEP_JCNT = 6'h24;
    localparam int CTRL_START = 0;
    localparam int CTRL_HOLD = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_BRANCH = 3;
    localparam int STAT_WAIT = 3;
    localparam int STAT_TERM = 4;
    localparam int STAT_STEP_LSB = 8;
    localparam int LVL_AC_LSB = 16;
    localparam int CFG_SYNC_LSB = 0;
    localparam int CFG_ENDPH = 2;
    localparam int CFG_TERM_LSB = 4;
    localparam int CFG_JUMP_LSB = 8;
    localparam int CFG_BRANCH_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [31:0] oss_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : oss_merge
endpackage : oss_pkg

/* hw/oss_step_timer.sv */
// step time counter in 0.1 ms units
`timescale 1ns/1ps
module oss_step_timer
    import oss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [TIME_W-1:0] i_load_val,
    input wire logic i_run,
    output logic o_expired
);
    typedef struct packed {
        logic [11:0] pre;
        logic [TIME_W-1:0] left;
        logic expired;
    } oss_tmr_s;

    oss_tmr_s s_ff;
    oss_tmr_s nxt_s;

    // counting only while running keeps the remaining time across hold
    always_comb begin
        nxt_s = s_ff;
        if (i_load) begin
            nxt_s.pre = '0;
            nxt_s.left = i_load_val;
        end else if (i_run && s_ff.left != '0) begin
            if (s_ff.pre == TICK_LAST) begin
                nxt_s.pre = '0;
                nxt_s.left = s_ff.left - 1'b1;
            end else begin
                nxt_s.pre = s_ff.pre + 1'b1;
            end
        end
        nxt_s.expired = (nxt_s.left == '0);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_ff <= '0;
            s_ff.expired <= 1'b1;
        end else if (i_ce) begin
            s_ff <= nxt_s;
        end
    end

    assign o_expired = s_ff.expired;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    load_clears_a: assert property (i_ce && i_load && i_load_val != '0 |=> !o_expired)
        else $error("loaded step time reads as expired");
    paused_time_a: assert property (i_ce && !i_run && !i_load |=> $stable(s_ff.left))
        else $error("step time moved while paused");
endmodule : oss_step_timer

/* hw/oss_seq.sv */
// output step sequencer with axi4-lite register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module oss_seq
    import oss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_phase_zero,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [LVL_W-1:0] o_dc_level,
    output logic [LVL_W-1:0] o_ac_level,
    output logic [SYNC_W-1:0] o_sync_code,
    output logic [2:0] o_seq_state,
    output logic [STEP_W-1:0] o_step
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        oss_state_e state;
        logic [STEP_W-1:0] step;
        logic term_hold;
        logic [LVL_W-1:0] dc;
        logic [LVL_W-1:0] ac;
        logic [SYNC_W-1:0] sync;
        logic [LVL_W-1:0] reg_dc;
        logic [LVL_W-1:0] reg_ac;
        logic [STEP_W-1:0] num_steps;
        logic [STEP_W-1:0] sel;
        logic awready;
        logic [ADDR_W-1:0] aw_addr;
        logic wready;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } oss_seq_s;

    oss_seq_s s_ff;
    oss_seq_s nxt_s;

    // step memories, index 0 unused
    logic [31:0] mem_lvl [0:255];
    logic [TIME_W-1:0] mem_time [0:255];
    logic [31:0] mem_cfg [0:255];
    logic [JCNT_W-1:0] mem_jcnt [0:255];
    logic [JCNT_W-1:0] jcnt_ff [0:255];

    logic t_expired;
    logic t_load;
    logic [TIME_W-1:0] t_val;
    logic commit;
    logic wr_ctrl;
    logic c_start;
    logic c_hold;
    logic c_stop;
    logic c_branch;
    logic step_end;
    logic waiting;
    logic go;
    logic [STEP_W-1:0] go_step;
    logic jc_clr_all;
    logic jc_inc;
    logic jc_zero;
    logic [31:0] cur_cfg;
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic [STEP_W-1:0] nx_step;

    assign cur_cfg = mem_cfg[s_ff.step];
    assign nx_step = s_ff.step + 1'b1;

    oss_step_timer u_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_load(t_load),
        .i_load_val(t_val),
        .i_run(s_ff.state == OSS_RUN),
        .o_expired(t_expired)
    );

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case (i_araddr)
            ADDR_CTRL: rd_val = '0;
            ADDR_STATUS: begin
                rd_val[2:0] = s_ff.state;
                rd_val[STAT_WAIT] = waiting;
                rd_val[STAT_TERM] = s_ff.term_hold;
                rd_val[STAT_STEP_LSB +: STEP_W] = s_ff.step;
            end
            ADDR_REG_DC: rd_val[LVL_W-1:0] = s_ff.reg_dc;
            ADDR_REG_AC: rd_val[LVL_W-1:0] = s_ff.reg_ac;
            ADDR_NUM_STEPS: rd_val[STEP_W-1:0] = s_ff.num_steps;
            ADDR_STEP_SEL: rd_val[STEP_W-1:0] = s_ff.sel;
            ADDR_STEP_LVL: rd_val = mem_lvl[s_ff.sel];
            ADDR_STEP_TIME: rd_val[TIME_W-1:0] = mem_time[s_ff.sel];
            ADDR_STEP_CFG: rd_val = mem_cfg[s_ff.sel];
            ADDR_STEP_JCNT: rd_val[JCNT_W-1:0] = mem_jcnt[s_ff.sel];
            default: rd_ok = 1'b0;
        endcase
    end

    // ----------------------------------------
    // bus write and control decode
    // ----------------------------------------
    assign commit = !s_ff.awready && !s_ff.wready && !s_ff.bvalid;
    assign wr_ok = (s_ff.aw_addr <= ADDR_STEP_JCNT) && (s_ff.aw_addr[1:0] == 2'h0);
    assign wr_ctrl = commit && s_ff.aw_addr == ADDR_CTRL && s_ff.w_strb[0];
    assign c_start = wr_ctrl && s_ff.w_data[CTRL_START];
    assign c_hold = wr_ctrl && s_ff.w_data[CTRL_HOLD];
    assign c_stop = wr_ctrl && s_ff.w_data[CTRL_STOP];
    assign c_branch = wr_ctrl && s_ff.w_data[CTRL_BRANCH];

    // a step ends only after its time and, if asked, at zero phase
    assign waiting = s_ff.state == OSS_RUN && t_expired && cur_cfg[CFG_ENDPH] && !i_phase_zero;
    assign step_end = s_ff.state == OSS_RUN && t_expired
                      && (!cur_cfg[CFG_ENDPH] || i_phase_zero);

    // ----------------------------------------
    // sequencer and bus next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        go = 1'b0;
        go_step = STEP_NONE;
        jc_clr_all = 1'b0;
        jc_inc = 1'b0;
        jc_zero = 1'b0;
        t_load = 1'b0;
        t_val = '0;
        // bus channels
        if (i_awvalid && s_ff.awready) begin
            nxt_s.awready = 1'b0;
            nxt_s.aw_addr = i_awaddr;
        end
        if (i_wvalid && s_ff.wready) begin
            nxt_s.wready = 1'b0;
            nxt_s.w_data = i_wdata;
            nxt_s.w_strb = i_wstrb;
        end
        if (commit) begin
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
            case (s_ff.aw_addr)
                ADDR_REG_DC: nxt_s.reg_dc = LVL_W'(oss_merge(32'(s_ff.reg_dc),
                                               s_ff.w_data, s_ff.w_strb));
                ADDR_REG_AC: nxt_s.reg_ac = LVL_W'(oss_merge(32'(s_ff.reg_ac),
                                               s_ff.w_data, s_ff.w_strb));
                ADDR_NUM_STEPS: nxt_s.num_steps = STEP_W'(oss_merge(32'(s_ff.num_steps),
                                               s_ff.w_data, s_ff.w_strb));
                ADDR_STEP_SEL: nxt_s.sel = STEP_W'(oss_merge(32'(s_ff.sel),
                                               s_ff.w_data, s_ff.w_strb));
                default: nxt_s.bresp = nxt_s.bresp;
            endcase
        end
        if (s_ff.bvalid && i_bready) begin
            nxt_s.bvalid = 1'b0;
            nxt_s.awready = 1'b1;
            nxt_s.wready = 1'b1;
        end
        if (i_arvalid && s_ff.arready) begin
            nxt_s.arready = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rd_val;
            nxt_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_ff.rvalid && i_rready) begin
            nxt_s.rvalid = 1'b0;
            nxt_s.arready = 1'b1;
        end
        // sequence control: stop, hold, start, branch, step end
        if (c_stop && s_ff.state != OSS_IDLE) begin
            nxt_s.state = OSS_IDLE;
            nxt_s.reg_dc = s_ff.dc;
            nxt_s.reg_ac = s_ff.ac;
            nxt_s.term_hold = 1'b0;
        end else if (c_hold && s_ff.state == OSS_RUN) begin
            nxt_s.state = OSS_HOLD;
            nxt_s.term_hold = 1'b0;
        end else if (c_start && s_ff.state != OSS_RUN) begin
            case (s_ff.state)
                OSS_IDLE: begin
                    go = 1'b1;
                    go_step = FIRST_STEP;
                    jc_clr_all = 1'b1;
                end
                OSS_HOLD: begin
                    nxt_s.term_hold = 1'b0;
                    nxt_s.state = OSS_RUN;
                    if (s_ff.term_hold) begin
                        go = 1'b1;
                        go_step = (cur_cfg[CFG_JUMP_LSB +: STEP_W] == STEP_NONE)
                                  ? nx_step : cur_cfg[CFG_JUMP_LSB +: STEP_W];
                    end
                end
                default: nxt_s.state = s_ff.state;
            endcase
        end else if (c_branch && s_ff.state != OSS_IDLE) begin
            if (cur_cfg[CFG_BRANCH_LSB +: STEP_W] != STEP_NONE) begin
                go = 1'b1;
                go_step = cur_cfg[CFG_BRANCH_LSB +: STEP_W];
            end
        end else if (step_end) begin
            // termination outranks the jump step
            case (cur_cfg[CFG_TERM_LSB +: 2])
                TERM_HOLD: begin
                    nxt_s.state = OSS_HOLD;
                    nxt_s.term_hold = 1'b1;
                end
                TERM_STOP: begin
                    nxt_s.state = OSS_IDLE;
                    nxt_s.reg_dc = s_ff.dc;
                    nxt_s.reg_ac = s_ff.ac;
                end
                default: begin
                    go = 1'b1;
                    go_step = nx_step;
                    if (cur_cfg[CFG_JUMP_LSB +: STEP_W] != STEP_NONE) begin
                        if (mem_jcnt[s_ff.step] == JCNT_INF
                            || jcnt_ff[s_ff.step] < mem_jcnt[s_ff.step]) begin
                            jc_inc = 1'b1;
                            go_step = cur_cfg[CFG_JUMP_LSB +: STEP_W];
                        end else begin
                            jc_zero = 1'b1;
                        end
                    end
                end
            endcase
        end
        // entering a step; running past the last step ends the sequence
        if (go) begin
            if (go_step == STEP_NONE || go_step > s_ff.num_steps) begin
                nxt_s.state = OSS_IDLE;
                nxt_s.reg_dc = s_ff.dc;
                nxt_s.reg_ac = s_ff.ac;
            end else begin
                nxt_s.state = OSS_RUN;
                nxt_s.step = go_step;
                nxt_s.dc = mem_lvl[go_step][LVL_W-1:0];
                nxt_s.ac = mem_lvl[go_step][LVL_AC_LSB +: LVL_W];
                nxt_s.sync = mem_cfg[go_step][CFG_SYNC_LSB +: SYNC_W];
                t_load = 1'b1;
                t_val = mem_time[go_step];
            end
        end
        // in idle the regular output step owns the outputs
        if (nxt_s.state == OSS_IDLE) begin
            nxt_s.dc = nxt_s.reg_dc;
            nxt_s.ac = nxt_s.reg_ac;
            nxt_s.sync = SYNC_FALSE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_ff <= '0;
            s_ff.state <= OSS_IDLE;
            s_ff.awready <= 1'b1;
            s_ff.wready <= 1'b1;
            s_ff.arready <= 1'b1;
        end else if (i_ce) begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // step memory and per-step jump counters
    // ----------------------------------------
    // memories hold no reset; software programs steps before start
    always_ff @(posedge i_clk) begin
        if (i_ce && commit) begin
            case (s_ff.aw_addr)
                ADDR_STEP_LVL: mem_lvl[s_ff.sel] <= oss_merge(mem_lvl[s_ff.sel],
                                                    s_ff.w_data, s_ff.w_strb);
                ADDR_STEP_TIME: mem_time[s_ff.sel] <= TIME_W'(oss_merge(
                    32'(mem_time[s_ff.sel]), s_ff.w_data, s_ff.w_strb));
                ADDR_STEP_CFG: mem_cfg[s_ff.sel] <= oss_merge(mem_cfg[s_ff.sel],
                                                    s_ff.w_data, s_ff.w_strb);
                ADDR_STEP_JCNT: mem_jcnt[s_ff.sel] <= JCNT_W'(oss_merge(
                    32'(mem_jcnt[s_ff.sel]), s_ff.w_data, s_ff.w_strb));
                default: mem_lvl[0] <= mem_lvl[0];
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_ce && jc_clr_all)) begin
            for (int i = 0; i < 256; i++) begin
                jcnt_ff[i] <= '0;
            end
        end else if (i_ce && jc_inc) begin
            jcnt_ff[s_ff.step] <= jcnt_ff[s_ff.step] + 1'b1;
        end else if (i_ce && jc_zero) begin
            jcnt_ff[s_ff.step] <= '0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_awready = s_ff.awready;
    assign o_wready = s_ff.wready;
    assign o_bresp = s_ff.bresp;
    assign o_bvalid = s_ff.bvalid;
    assign o_arready = s_ff.arready;
    assign o_rdata = s_ff.rdata;
    assign o_rresp = s_ff.rresp;
    assign o_rvalid = s_ff.rvalid;
    assign o_dc_level = s_ff.dc;
    assign o_ac_level = s_ff.ac;
    assign o_sync_code = s_ff.sync;
    assign o_seq_state = s_ff.state;
    assign o_step = s_ff.step;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    idle_sync_a: assert property (s_ff.state == OSS_IDLE |-> s_ff.sync == SYNC_FALSE)
        else $error("sync code active in idle");
    stop_copy_a: assert property (i_ce && c_stop && s_ff.state != OSS_IDLE
        |=> s_ff.state == OSS_IDLE && s_ff.reg_dc == $past(s_ff.dc)
            && o_dc_level == $past(s_ff.dc))
        else $error("stop did not keep the output");
    start_idle_a: assert property (i_ce && c_start && s_ff.state == OSS_IDLE
        && s_ff.num_steps != STEP_NONE |=> s_ff.state == OSS_RUN && s_ff.step == FIRST_STEP)
        else $error("start from idle missed step one");
    hold_enter_a: assert property (i_ce && c_hold && !c_stop && s_ff.state == OSS_RUN
        |=> s_ff.state == OSS_HOLD)
        else $error("hold control not taken");
    hold_freeze_a: assert property (s_ff.state == OSS_HOLD && !c_stop && !c_start && !c_branch
        |=> $stable(o_dc_level) && $stable(o_ac_level) && $stable(o_step))
        else $error("output moved in hold");
    idle_ignore_a: assert property (i_ce && s_ff.state == OSS_IDLE && !c_start
        |=> s_ff.state == OSS_IDLE)
        else $error("idle left without start");
    phase_wait_a: assert property (i_ce && waiting && !wr_ctrl
        |=> $stable(o_step) && $stable(o_dc_level) && $stable(o_sync_code))
        else $error("step left before zero phase");
    run_sync_a: assert property (i_ce && go && t_load
        |=> o_sync_code == $past(mem_cfg[go_step][CFG_SYNC_LSB +: SYNC_W]))
        else $error("step sync code not driven");
    bus_resp_a: assert property (i_ce && commit |=> o_bvalid ##0 !o_awready && !o_wready)
        else $error("write response missing");
endmodule : oss_seq

/* sim/oss_host.sv */
// axi4-lite host model issuing sequence controls and register traffic
`timescale 1ns/1ps
module oss_host
    import oss_pkg::*;
(
    input wire logic i_clk,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_awvalid,
    input wire logic i_awready,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    output logic o_wvalid,
    input wire logic i_wready,
    input wire logic [1:0] i_bresp,
    input wire logic i_bvalid,
    output logic o_bready,
    output logic o_arvalid,
    input wire logic i_arready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp,
    input wire logic i_rvalid,
    output logic o_rready
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // one transfer at a time, so reads and writes share one address line
    initial begin
        o_addr = '0;
        o_awvalid = 1'b0;
        o_wdata = '0;
        o_wstrb = 4'hF;
        o_wvalid = 1'b0;
        o_bready = 1'b0;
        o_arvalid = 1'b0;
        o_rready = 1'b0;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (o_awvalid && i_awready) o_awvalid <= 1'b0;
            if (o_wvalid && i_wready) o_wvalid <= 1'b0;
            if (i_bvalid) begin
                r = i_bresp;
                o_bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        o_addr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (o_arvalid && i_arready) o_arvalid <= 1'b0;
            if (i_rvalid) begin
                d = i_rdata;
                r = i_rresp;
                o_rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : oss_host

/* sim/testbench.sv */
// self-checking bench of the output step sequencer
`timescale 1ns/1ps
module testbench;
    import oss_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_phase_zero = 1'b0;
    logic i_ce = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [31:0] i_wdata, o_rdata, rd_v;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, o_sync_code, rsp;
    logic [LVL_W-1:0] o_dc_level, o_ac_level;
    logic [2:0] o_seq_state;
    logic [STEP_W-1:0] o_step;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic i_arvalid, o_arready, o_rvalid, i_rready;
    int num_errors = 0;
    int n_checks = 0;
    // step n: dc 0x0101*n, ac 0x0011*n, sync n; step 2 loops once to 1, branches to 3
    logic [37:0] prog [18] = '{{ADDR_REG_DC, 32'h1234}, {ADDR_REG_AC, 32'h56},
        {ADDR_NUM_STEPS, 32'h3}, {ADDR_STEP_SEL, 32'h1}, {ADDR_STEP_LVL, 32'h110101},
        {ADDR_STEP_TIME, 32'h1}, {ADDR_STEP_CFG, 32'h1}, {ADDR_STEP_JCNT, 32'h0},
        {ADDR_STEP_SEL, 32'h2}, {ADDR_STEP_LVL, 32'h220202}, {ADDR_STEP_TIME, 32'h1},
        {ADDR_STEP_CFG, 32'h30102}, {ADDR_STEP_JCNT, 32'h1}, {ADDR_STEP_SEL, 32'h3},
        {ADDR_STEP_LVL, 32'h330303}, {ADDR_STEP_TIME, 32'h1}, {ADDR_STEP_CFG, 32'h217},
        {ADDR_STEP_JCNT, 32'h0}};
    logic [39:0] rows [6] = '{{ADDR_CTRL, 32'h0, RESP_OKAY}, {ADDR_STATUS, 32'h1, RESP_OKAY},
        {ADDR_REG_DC, 32'h1234, RESP_OKAY}, {ADDR_REG_AC, 32'h56, RESP_OKAY},
        {ADDR_NUM_STEPS, 32'h3, RESP_OKAY}, {6'h28, 32'h0, RESP_SLVERR}};
    logic [7:0] order [4] = '{8'h02, 8'h01, 8'h02, 8'h03};

    oss_seq dut_u (.i_clk, .i_reset_n, .i_ce, .i_phase_zero, .i_awaddr(addr), .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr(addr), .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .o_dc_level, .o_ac_level, .o_sync_code, .o_seq_state, .o_step);
    oss_host host_u (.i_clk, .o_addr(addr), .o_awvalid(i_awvalid), .i_awready(o_awready),
        .o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_wvalid(i_wvalid), .i_wready(o_wready),
        .i_bresp(o_bresp), .i_bvalid(o_bvalid), .o_bready(i_bready), .o_arvalid(i_arvalid),
        .i_arready(o_arready), .i_rdata(o_rdata), .i_rresp(o_rresp), .i_rvalid(o_rvalid),
        .o_rready(i_rready));

    always #12.5 i_clk = ~i_clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    // the step number in idle is left open, so it is only compared outside idle
    task automatic see(input logic [2:0] st, input logic [7:0] sp, input logic [15:0] dc,
                       input logic [1:0] sy);
        chk(32'(o_seq_state), 32'(st));
        if (st !== OSS_IDLE) chk(32'(o_step), 32'(sp));
        chk(32'(o_dc_level), 32'(dc));
        chk(32'(o_sync_code), 32'(sy));
    endtask : see
    task automatic ctl(input logic [3:0] c);
        host_u.wr(ADDR_CTRL, {28'h0, c}, rsp);
        tick(2);
    endtask : ctl
    task automatic next_step(input logic [7:0] sp);
        logic [7:0] was;
        int n;
        was = o_step;
        n = 0;
        while (o_step === was && n < 9000) begin
            tick(1);
            n++;
        end
        tick(1);
        see(OSS_RUN, sp, 16'(16'h0101 * sp), 2'(sp));
        chk(32'(o_ac_level), 32'(16'(16'h0011 * sp)));
    endtask : next_step
    task automatic summarize();
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #2000000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        tick(2);
        see(OSS_IDLE, 8'h00, 16'h0000, 2'h0);
        foreach (prog[i]) begin
            host_u.wr(prog[i][37:32], prog[i][31:0], rsp);
            chk(32'(rsp), 32'(RESP_OKAY));
        end
        host_u.wr(6'h28, 32'h0, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        foreach (rows[i]) begin
            host_u.rd(rows[i][39:34], rd_v, rsp);
            chk(rd_v, rows[i][33:2]);
            chk(32'(rsp), 32'(rows[i][1:0]));
        end
        see(OSS_IDLE, 8'h00, 16'h1234, 2'h0);
        chk(32'(o_ac_level), 32'h56);
        ctl(4'h2);
        ctl(4'h8);
        see(OSS_IDLE, 8'h00, 16'h1234, 2'h0);
        ctl(4'h1);
        see(OSS_RUN, 8'h01, 16'h0101, 2'h1);
        ctl(4'h2);
        tick(6000);
        see(OSS_HOLD, 8'h01, 16'h0101, 2'h1);
        ctl(4'h1);
        see(OSS_RUN, 8'h01, 16'h0101, 2'h1);
        foreach (order[i]) next_step(order[i]);
        tick(4500);
        see(OSS_RUN, 8'h03, 16'h0303, 2'h3);
        // a frozen clock enable must hold off the zero-phase point until the enable returns
        @(posedge i_clk);
        i_ce <= 1'b0;
        i_phase_zero <= 1'b1;
        tick(3);
        see(OSS_RUN, 8'h03, 16'h0303, 2'h3);
        @(posedge i_clk);
        i_ce <= 1'b1;
        @(posedge i_clk);
        i_phase_zero <= 1'b0;
        tick(3);
        see(OSS_HOLD, 8'h03, 16'h0303, 2'h3);
        ctl(4'h1);
        see(OSS_RUN, 8'h02, 16'h0202, 2'h2);
        ctl(4'h8);
        see(OSS_RUN, 8'h03, 16'h0303, 2'h3);
        ctl(4'h4);
        see(OSS_IDLE, 8'h00, 16'h0303, 2'h0);
        chk(32'(o_ac_level), 32'h33);
        host_u.rd(ADDR_REG_AC, rd_v, rsp);
        chk(rd_v, 32'h33);
        // reset in mid-run must drop back to a cleared regular output
        ctl(4'h1);
        see(OSS_RUN, 8'h01, 16'h0101, 2'h1);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        tick(2);
        see(OSS_IDLE, 8'h00, 16'h0000, 2'h0);
        chk(32'(o_ac_level), 32'h0);
        summarize();
    end
endmodule : testbench
